// ### agc_pkg.sv
// constants and carrier types for the receive gain loop
package agc_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] AGC_ADDR_CTRL   = 8'h1d; // gain_loop_control
  localparam logic [7:0] AGC_ADDR_TARGET = 8'h1b; // amplitude_goal
  localparam logic [7:0] AGC_ADDR_STATUS = 8'h1e; // gain readback
  localparam logic [7:0] AGC_CTRL_RESET   = 8'h91;
  localparam logic [7:0] AGC_TARGET_RESET = 8'h03;
  // field positions
  localparam int AGC_HYST_LSB = 6;
  localparam int AGC_WAIT_LSB = 4;
  localparam int AGC_HOLD_LSB = 2;
  localparam int AGC_FLEN_LSB = 0;
  // hold codes
  localparam logic [1:0] AGC_HOLD_NONE   = 2'h0;
  localparam logic [1:0] AGC_HOLD_SYNC   = 2'h1;
  localparam logic [1:0] AGC_HOLD_ANALOG = 2'h2;
  localparam logic [1:0] AGC_HOLD_ALL    = 2'h3;
  // sample counts and thresholds in dB
  localparam logic [6:0] AGC_WAIT_STEP = 7'h08;
  localparam logic [4:0] AGC_OOK_STEP  = 5'h04;
  localparam logic [5:0] AGC_GOAL_BASE = 6'h18;
  localparam logic [3:0] AGC_ANA_MAX = 4'h7;
  localparam logic [3:0] AGC_DIG_MAX = 4'h7;

  typedef struct packed {
    logic [1:0] hyst;
    logic [1:0] wait_sel;
    logic [1:0] hold;
    logic [1:0] flen;
  } agc_ctrl_t;

  typedef enum logic [1:0] {
    AGC_SETTLE = 2'b00,
    AGC_ACCUM  = 2'b01,
    AGC_DECIDE = 2'b10
  } agc_state_t;
endpackage

// ### agc_gain_control.sv
// receive gain loop: control register, settle, average and gain steps
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - two-bit hysteresis field sets deviation hysteresis
// - code 0 small symmetric dead zone
// - code 1 small asymmetric dead zone
// - code 2 default medium asymmetric dead zone
// - code 3 large asymmetric dead zone
// - skip 8/16/24/32 samples after gain change
// - hold code 0 adjusts gain normally
// - hold code 1 freezes after sync
// - hold code 2 freezes analog gain only
// - hold code 3 freezes both gains
// - non-OOK average 8/16/32/64 samples
// - OOK boundary 4/8/12/16 dB
// - regulate toward 24 to 42 dB goal
module agc_gain_control
  import agc_pkg::*;
#(
  parameter int AMP_W = 6
) (
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  input  wire logic             sample_valid,
  input  wire logic [AMP_W-1:0] sample_amp,
  input  wire logic             ook_mode,
  input  wire logic             sync_found,
  output logic      [3:0]       analog_atten,
  output logic      [3:0]       digital_atten,
  output logic      [4:0]       ook_boundary,
  output logic                  gain_changed
);
  // ==========================================================
  // registers
  agc_ctrl_t  ctrl, next_ctrl;
  logic [2:0] goal, next_goal;
  logic [7:0] next_rdata;
  logic       sync_lock, next_sync_lock;

  // decode writes; reads answer one cycle later, unmapped read zero
  always_comb begin
    next_ctrl  = ctrl;
    next_goal  = goal;
    next_rdata = 8'h00;
    if (reg_wr && reg_addr == AGC_ADDR_CTRL) next_ctrl = agc_ctrl_t'(reg_wdata);
    if (reg_wr && reg_addr == AGC_ADDR_TARGET) next_goal = reg_wdata[2:0];
    if (reg_rd) begin
      case (reg_addr)
        AGC_ADDR_CTRL:   next_rdata = ctrl;
        AGC_ADDR_TARGET: next_rdata = {5'h00, goal};
        AGC_ADDR_STATUS: next_rdata = {analog_atten, digital_atten};
        default:         next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl      <= agc_ctrl_t'(AGC_CTRL_RESET);
      goal      <= AGC_TARGET_RESET[2:0];
      reg_rdata <= 8'h00;
    end else begin
      ctrl      <= next_ctrl;
      goal      <= next_goal;
      reg_rdata <= next_rdata;
    end
  end

  // ==========================================================
  // derived settings, recomputed every sample from live fields
  logic [6:0] wait_len;
  logic [6:0] avg_len;
  logic [5:0] goal_db;
  logic [2:0] dz_lo, dz_hi;
  always_comb begin
    wait_len = 7'((ctrl.wait_sel + 7'h1) * AGC_WAIT_STEP);
    avg_len  = 7'(7'h08 << ctrl.flen);
    case (goal)
      3'h5:    goal_db = AGC_GOAL_BASE + 6'h0e;
      3'h6:    goal_db = AGC_GOAL_BASE + 6'h10;
      3'h7:    goal_db = AGC_GOAL_BASE + 6'h12;
      default: goal_db = 6'(AGC_GOAL_BASE + 6'(goal) * 6'h3);
    endcase
    // dead zone below / above goal; gain held inside it
    case (ctrl.hyst)
      2'h0:    begin dz_lo = 3'h1; dz_hi = 3'h1; end
      2'h1:    begin dz_lo = 3'h1; dz_hi = 3'h2; end
      2'h2:    begin dz_lo = 3'h2; dz_hi = 3'h4; end
      default: begin dz_lo = 3'h3; dz_hi = 3'h6; end
    endcase
  end

  // ==========================================================
  // loop state
  agc_state_t state, next_state;
  logic [6:0] cnt, next_cnt;
  logic [12:0] acc, next_acc;
  logic [3:0] next_ana, next_dig;
  logic [4:0] next_ook;
  logic       next_changed;
  logic [AMP_W-1:0] avg;
  logic       hold_ana, hold_dig;

  always_comb begin
    // shift of flen+3 needs three bits, two would wrap for codes 1 to 3
    avg      = AMP_W'(acc >> (3'(ctrl.flen) + 3'd3));
    hold_dig = (ctrl.hold == AGC_HOLD_ALL) ||
               (ctrl.hold == AGC_HOLD_SYNC && sync_lock);
    hold_ana = hold_dig || ctrl.hold == AGC_HOLD_ANALOG;
    next_sync_lock = sync_lock;
    if (ctrl.hold != AGC_HOLD_SYNC) next_sync_lock = 1'b0;
    else if (sync_found) next_sync_lock = 1'b1;
    next_state   = state;
    next_cnt     = cnt;
    next_acc     = acc;
    next_ana     = analog_atten;
    next_dig     = digital_atten;
    next_changed = 1'b0;
    next_ook     = 5'((ctrl.flen + 5'h1) * AGC_OOK_STEP);
    case (state)
      AGC_SETTLE: if (sample_valid) begin
        if (cnt + 7'h1 >= wait_len) begin
          next_state = AGC_ACCUM;
          next_cnt   = 7'h00;
          next_acc   = 13'h0000;
        end else next_cnt = cnt + 7'h1;
      end
      AGC_ACCUM: if (sample_valid) begin
        next_acc = acc + 13'(sample_amp);
        if (cnt + 7'h1 >= avg_len) next_state = AGC_DECIDE;
        else next_cnt = cnt + 7'h1;
      end
      AGC_DECIDE: begin
        next_state = AGC_ACCUM;
        next_cnt   = 7'h00;
        next_acc   = 13'h0000;
        // too strong: attenuate, analog first while allowed
        if (!ook_mode && 7'(avg) > 7'(goal_db) + 7'(dz_hi)) begin
          if (!hold_ana && analog_atten < AGC_ANA_MAX) next_ana = analog_atten + 4'h1;
          else if (!hold_dig && digital_atten < AGC_DIG_MAX)
            next_dig = digital_atten + 4'h1;
        end else if (!ook_mode && 7'(avg) + 7'(dz_lo) < 7'(goal_db)) begin
          if (!hold_dig && digital_atten != 4'h0) next_dig = digital_atten - 4'h1;
          else if (!hold_ana && analog_atten != 4'h0) next_ana = analog_atten - 4'h1;
        end
        if (next_ana != analog_atten || next_dig != digital_atten) begin
          next_changed = 1'b1;
          next_state   = AGC_SETTLE;
        end
      end
      default: next_state = AGC_SETTLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state         <= AGC_SETTLE;
      cnt           <= 7'h00;
      acc           <= 13'h0000;
      analog_atten  <= 4'h0;
      digital_atten <= 4'h0;
      ook_boundary  <= 5'h08;
      gain_changed  <= 1'b0;
      sync_lock     <= 1'b0;
    end else begin
      state         <= next_state;
      cnt           <= next_cnt;
      acc           <= next_acc;
      analog_atten  <= next_ana;
      digital_atten <= next_dig;
      ook_boundary  <= next_ook;
      gain_changed  <= next_changed;
      sync_lock     <= next_sync_lock;
    end
  end

  // ==========================================================
  // helper for the settle check: samples taken in this settle
  // phase, counted apart from cnt so a wrong cnt cannot hide
  logic [6:0] settle_seen, next_settle_seen;
  logic [6:0] settle_rule;

  // rule length from the field, running count while settling
  always_comb begin
    settle_rule      = 7'({ctrl.wait_sel, 3'b000}) + AGC_WAIT_STEP;
    next_settle_seen = 7'h00;
    if (state == AGC_SETTLE) begin
      next_settle_seen = settle_seen;
      if (sample_valid) next_settle_seen = settle_seen + 7'h1;
    end
  end

  // zero after every cycle in which the loop is not settling
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) settle_seen <= 7'h00;
    else settle_seen <= next_settle_seen;
  end

  // ==========================================================
  // assertions
  property p_hold_all;
    @(posedge clk_sys) disable iff (!rstn)
      ctrl.hold == AGC_HOLD_ALL && $past(ctrl.hold) == AGC_HOLD_ALL
        |-> $stable(analog_atten) && $stable(digital_atten);
  endproperty
  a_hold_all: assert property (p_hold_all) else $error("gain moved while fully held");

  property p_hold_analog;
    @(posedge clk_sys) disable iff (!rstn)
      ctrl.hold == AGC_HOLD_ANALOG && $past(ctrl.hold) == AGC_HOLD_ANALOG
        |-> $stable(analog_atten);
  endproperty
  a_hold_analog: assert property (p_hold_analog) else $error("analog gain moved");

  property p_settle_after_change;
    @(posedge clk_sys) disable iff (!rstn)
      gain_changed |-> state == AGC_SETTLE && cnt == 7'h00;
  endproperty
  a_settle_after_change: assert property (p_settle_after_change) else $error("no settle");

  property p_ook_boundary;
    @(posedge clk_sys) disable iff (!rstn)
      ##1 ook_boundary == 5'(($past(ctrl.flen) + 5'h1) * 5'h4);
  endproperty
  a_ook_boundary: assert property (p_ook_boundary) else $error("bad ook boundary");

  property p_sync_freeze;
    @(posedge clk_sys) disable iff (!rstn)
      sync_lock && ctrl.hold == AGC_HOLD_SYNC |=> $stable(digital_atten);
  endproperty
  a_sync_freeze: assert property (p_sync_freeze) else $error("gain moved after sync");

  property p_accum_len;
    @(posedge clk_sys) disable iff (!rstn)
      state == AGC_ACCUM |-> cnt < avg_len;
  endproperty
  a_accum_len: assert property (p_accum_len) else $error("average overran");

  property p_step_one;
    @(posedge clk_sys) disable iff (!rstn)
      $changed(analog_atten) |-> $past(state) == AGC_DECIDE && gain_changed;
  endproperty
  a_step_one: assert property (p_step_one) else $error("stray gain step");

  property p_rd_latency;
    @(posedge clk_sys) disable iff (!rstn)
      reg_rd && reg_addr == AGC_ADDR_CTRL && !reg_wr |=> reg_rdata == $past(ctrl);
  endproperty
  a_rd_latency: assert property (p_rd_latency) else $error("read data wrong");

  // settle phase length, counted independently of the loop counter
  property p_settle_len;
    @(posedge clk_sys) disable iff (!rstn)
      state == AGC_ACCUM && $past(state) == AGC_SETTLE
        |-> settle_seen >= $past(settle_rule) && settle_seen <= 7'(4 * AGC_WAIT_STEP);
  endproperty
  a_settle_len: assert property (p_settle_len) else $error("settle too short");

  // ook reception never moves the gain
  property p_ook_no_step;
    @(posedge clk_sys) disable iff (!rstn)
      state == AGC_DECIDE && ook_mode |=> !gain_changed;
  endproperty
  a_ook_no_step: assert property (p_ook_no_step) else $error("step in ook");

  // inside the dead zone the decision leaves both gains alone
  property p_dead_zone;
    @(posedge clk_sys) disable iff (!rstn)
      state == AGC_DECIDE && 7'(avg) <= 7'(goal_db) + 7'(dz_hi) &&
        7'(avg) + 7'(dz_lo) >= 7'(goal_db) |=> !gain_changed;
  endproperty
  a_dead_zone: assert property (p_dead_zone) else $error("step in dead zone");

  // normal operation: too strong adds one analog step
  property p_strong_step;
    @(posedge clk_sys) disable iff (!rstn)
      state == AGC_DECIDE && !ook_mode && ctrl.hold == AGC_HOLD_NONE &&
        7'(avg) > 7'(goal_db) + 7'(dz_hi) && analog_atten < AGC_ANA_MAX
        |=> gain_changed && analog_atten == $past(analog_atten) + 4'h1;
  endproperty
  a_strong_step: assert property (p_strong_step) else $error("no attenuation");

  // normal operation: too weak with digital at zero backs analog off
  property p_weak_step;
    @(posedge clk_sys) disable iff (!rstn)
      state == AGC_DECIDE && !ook_mode && ctrl.hold == AGC_HOLD_NONE &&
        7'(avg) + 7'(dz_lo) < 7'(goal_db) && digital_atten == 4'h0 && analog_atten != 4'h0
        |=> gain_changed && analog_atten == $past(analog_atten) - 4'h1;
  endproperty
  a_weak_step: assert property (p_weak_step) else $error("no gain restore");

  // sync freeze covers the analog path as well
  property p_sync_ana;
    @(posedge clk_sys) disable iff (!rstn)
      sync_lock && ctrl.hold == AGC_HOLD_SYNC |=> $stable(analog_atten);
  endproperty
  a_sync_ana: assert property (p_sync_ana) else $error("analog moved after sync");

  // main scenarios
  c_change: cover property (@(posedge clk_sys) disable iff (!rstn) gain_changed);
  c_settle_done: cover property (@(posedge clk_sys) disable iff (!rstn)
    state == AGC_SETTLE ##1 state == AGC_ACCUM);
  c_sync_lock: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(sync_lock));
  c_ook_decide: cover property (@(posedge clk_sys) disable iff (!rstn)
    state == AGC_DECIDE && ook_mode);
  c_digital_step: cover property (@(posedge clk_sys) disable iff (!rstn)
    $changed(digital_atten));
endmodule
`default_nettype wire

// ### tb_agc_gain_control.sv
// self-checking testbench for the receive gain loop
`timescale 1ns/1ps
`default_nettype none
module tb_agc_gain_control
  import agc_pkg::*;
;
  // ==========================================================
  // signals and counters
  logic       clk_sys, rstn, reg_wr, reg_rd, sample_valid, ook_mode, sync_found;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
  logic [5:0] sample_amp;
  logic [3:0] analog_atten, digital_atten;
  logic [4:0] ook_boundary;
  logic       gain_changed;
  int         n_errors = 0;
  int         cmp_count = 0;
  int         n_steps = 0;
  int         p0, p1, k;
  typedef struct {logic [7:0] ctrl; logic [4:0] bound; int gap;} agc_row_t;
  // gap is settle samples plus averaged samples between two steps
  agc_row_t rows [4] = '{'{8'h00, 5'h04, 16}, '{8'h11, 5'h08, 32},
                         '{8'h22, 5'h0c, 56}, '{8'h33, 5'h10, 96}};
  int       hi_zone [4] = '{1, 2, 4, 6};
  int       lo_zone [4] = '{1, 1, 2, 3};

  agc_gain_control #(.AMP_W(6)) agc_gain_control_i (
    .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .sample_amp(sample_amp), .ook_mode(ook_mode),
    .sync_found(sync_found), .analog_atten(analog_atten),
    .digital_atten(digital_atten), .ook_boundary(ook_boundary),
    .gain_changed(gain_changed));

  // ==========================================================
  // clock and step counter
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (gain_changed === 1'b1) n_steps <= n_steps + 1;

  // ==========================================================
  // tasks; all but the time-zero rst_dut and the watchdog's end_of_test are entered just after a rising edge
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask
  // strobes drop for a cycle so no signal is assigned twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk_sys); reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk_sys); reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
    @(posedge clk_sys);
  endtask
  task automatic rst_dut();
    rstn <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
  endtask
  // spacing of five cycles keeps samples clear of the decide cycle
  task automatic send(input logic [5:0] a);
    sample_amp <= a; sample_valid <= 1'b1;
    @(posedge clk_sys); sample_valid <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic run_case(input logic [7:0] ctrl, input logic [7:0] goal,
                          input logic [5:0] amp, input logic ook, input logic sync,
                          input logic any, input logic ana0);
    int s0;
    rst_dut();
    wr(AGC_ADDR_TARGET, goal);
    wr(AGC_ADDR_CTRL, ctrl);
    ook_mode <= ook; sync_found <= sync;
    @(posedge clk_sys); sync_found <= 1'b0;
    s0 = n_steps;
    repeat (40) send(amp);
    chk("step_seen", {7'h0, any}, {7'h0, n_steps != s0});
    chk("analog_zero", {7'h0, ana0}, {7'h0, analog_atten === 4'h0});
    if (any && ana0) chk("digital_moved", 8'h01, {7'h0, digital_atten != 4'h0});
    rd(AGC_ADDR_STATUS);
    if (!any) chk("status", 8'h00, rd_val);
    ook_mode <= 1'b0;
    $display("test case ctrl %h amp %0d done", ctrl, amp);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================
  // watchdog: whole run needs about 7k cycles, limit is 20k
  initial begin
    #200000;
    n_errors++;
    end_of_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    rstn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
    sample_valid = 1'b0; sample_amp = 6'h00; ook_mode = 1'b0; sync_found = 1'b0;
    rst_dut();
    // rows: settle and average lengths, boundary per filter code
    for (int i = 0; i < 4; i++) begin
      rst_dut();
      wr(AGC_ADDR_TARGET, 8'h00); wr(AGC_ADDR_CTRL, rows[i].ctrl);
      rd(AGC_ADDR_CTRL); chk("ctrl_rw", rows[i].ctrl, rd_val);
      chk("ook_bound", {3'h0, rows[i].bound}, {3'h0, ook_boundary});
      k = 0; p0 = 0; p1 = 0;
      for (int s = 1; s <= 250 && k < 2; s++) begin
        int b;
        b = n_steps;
        send(6'h3f);
        if (n_steps != b) begin
          if (k == 0) p0 = s; else p1 = s;
          k++;
        end
      end
      chk("step_gap", 8'(rows[i].gap), 8'(p1 - p0));
      $display("test row %0d done", i);
    end
    // reset again mid-run: every field must fall back to its default
    rst_dut();
    rd(AGC_ADDR_CTRL); chk("ctrl_reset", 8'h91, rd_val);
    rd(AGC_ADDR_TARGET); chk("goal_reset", 8'h03, rd_val);
    chk("bound_reset", 8'h08, {3'h0, ook_boundary});
    wr(8'h00, 8'hff); rd(8'h00); chk("unmapped", 8'h00, rd_val);
    $display("test reset done");
    // upper dead zone edge for each hysteresis code
    for (int h = 0; h < 4; h++) begin
      logic [7:0] hc;
      hc = {2'(h), 6'h00};
      run_case(hc, 8'h00, 6'(24 + hi_zone[h]), 1'b0, 1'b0, 1'b0, 1'b1);
      run_case(hc, 8'h00, 6'(25 + hi_zone[h]), 1'b0, 1'b0, 1'b1, 1'b0);
    end
    // lower edge: raise analog once, then sit on and just past the edge
    for (int h = 0; h < 4; h++) begin
      logic [7:0] hc;
      hc = {2'(h), 6'h00};
      rst_dut();
      wr(AGC_ADDR_TARGET, 8'h00); wr(AGC_ADDR_CTRL, hc);
      repeat (16) send(6'h3f);
      repeat (16) send(6'(24 - lo_zone[h]));
      chk("weak_edge", 8'h01, {4'h0, analog_atten});
      repeat (8) send(6'(23 - lo_zone[h]));
      chk("weak_step", 8'h00, {4'h0, analog_atten});
      $display("test weak zone %0d done", h);
    end
    run_case(8'h00, 8'h07, 6'd43, 1'b0, 1'b0, 1'b0, 1'b1);
    run_case(8'h00, 8'h07, 6'd44, 1'b0, 1'b0, 1'b1, 1'b0);
    run_case(8'h00, 8'h05, 6'd39, 1'b0, 1'b0, 1'b0, 1'b1);
    run_case(8'h00, 8'h05, 6'd40, 1'b0, 1'b0, 1'b1, 1'b0);
    run_case(8'h04, 8'h00, 6'h3f, 1'b0, 1'b1, 1'b0, 1'b1);
    run_case(8'h04, 8'h00, 6'h3f, 1'b0, 1'b0, 1'b1, 1'b0);
    run_case(8'h08, 8'h00, 6'h3f, 1'b0, 1'b0, 1'b1, 1'b1);
    run_case(8'h0c, 8'h00, 6'h3f, 1'b0, 1'b0, 1'b0, 1'b1);
    run_case(8'h00, 8'h00, 6'h3f, 1'b1, 1'b0, 1'b0, 1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
